/* src/bffs_regs.vh */
// Register map, field layout, reset values and timing counts of the breaker-failure block
`ifndef BFFS_REGS_VH
`define BFFS_REGS_VH

// Register byte offsets
`define BFFS_OFF_CTRL        8'h00
`define BFFS_OFF_FT_THR      8'h04
`define BFFS_OFF_FC_PU       8'h08
`define BFFS_OFF_TT_PU       8'h0C
`define BFFS_OFF_TT_DO       8'h10
`define BFFS_OFF_TRIP_MASK   8'h14
`define BFFS_OFF_RMS_THR     8'h18
`define BFFS_OFF_STATUS      8'h1C

// Register indices returned by the decoder
`define BFFS_IDX_CTRL        4'h0
`define BFFS_IDX_FT_THR      4'h1
`define BFFS_IDX_FC_PU       4'h2
`define BFFS_IDX_TT_PU       4'h3
`define BFFS_IDX_TT_DO       4'h4
`define BFFS_IDX_TRIP_MASK   4'h5
`define BFFS_IDX_RMS_THR     4'h6
`define BFFS_IDX_STATUS      4'h7
`define BFFS_IDX_NONE        4'hF

// Scheme selector encoding in CTRL[2:0]
`define BFFS_SCH_OFF         3'h0
`define BFFS_SCH_ONE         3'h1
`define BFFS_SCH_TWO         3'h2
`define BFFS_SCH_THREE       3'h3
`define BFFS_SCH_FOUR        3'h4
`define BFFS_SCH_FIVE        3'h5
`define BFFS_SCH_CUSTOM      3'h6

// Field positions
`define BFFS_CTRL_SCH_MSB    2
`define BFFS_THR_MSB         12
`define BFFS_MASK_A_LSB      0
`define BFFS_MASK_B_LSB      8
`define BFFS_MASK_C_LSB      16
`define BFFS_ST_FBF_LSB      0
`define BFFS_ST_FD_LSB       4
`define BFFS_ST_OPEN_LSB     8
`define BFFS_ST_RMS_LSB      12
`define BFFS_ST_RMS3_BIT     15

// Reset values
`define BFFS_RST_CTRL        3'h0
`define BFFS_RST_FT_THR      13'h0032
`define BFFS_RST_FC_PU       16'h0020
`define BFFS_RST_TT_PU       16'h0020
`define BFFS_RST_TT_DO       16'h0008
`define BFFS_RST_TRIP_MASK   24'h040201
`define BFFS_RST_RMS_THR     13'h0032

// Timing: one processing tick is an eighth of a 60 Hz power cycle
`define BFFS_CLK_PERIOD_NS   10
`define BFFS_TICK_NS         2083333
`define BFFS_TICK_CYCLES     (`BFFS_TICK_NS / `BFFS_CLK_PERIOD_NS)
`define BFFS_QTR_TICKS       2'h2
`define BFFS_OPEN_TICKS      3'h5

`endif

/* src/bffs_core.v */
// Per-phase fault-current breaker-failure schemes with APB register access
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
`include "bffs_regs.vh"

module bffs_core #(
    parameter TICK_CYCLES = `BFFS_TICK_CYCLES
) (
    input  wire        clk_i,
    input  wire        rst_n_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [7:0]  paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    input  wire [7:0]  status_bits_i,
    input  wire [15:0] phase_a_mag_i,
    input  wire [15:0] phase_b_mag_i,
    input  wire [15:0] phase_c_mag_i,
    input  wire [15:0] phase_a_rms_i,
    input  wire [15:0] phase_b_rms_i,
    input  wire [15:0] phase_c_rms_i,
    input  wire [2:0]  current_zero_cross_i,
    input  wire [2:0]  deriv_zero_cross_i,
    output wire [2:0]  breaker_failure_flag_o,
    output wire [2:0]  phase_fault_detect_o,
    output wire [2:0]  phase_open_detect_o,
    output reg  [2:0]  phase_rms_overcurrent_o,
    output reg         three_phase_rms_overcurrent_o
);

    // Eighteen bits cover the full-rate tick count
    localparam [31:0] TICK_LAST_W = TICK_CYCLES - 1;
    localparam [17:0] TICK_LAST   = TICK_LAST_W[17:0];

    // Address decode shared by read and write paths
    function [3:0] reg_index;
        input [7:0] addr;
        begin
            if (addr == `BFFS_OFF_CTRL) begin
                reg_index = `BFFS_IDX_CTRL;
            end else if (addr == `BFFS_OFF_FT_THR) begin
                reg_index = `BFFS_IDX_FT_THR;
            end else if (addr == `BFFS_OFF_FC_PU) begin
                reg_index = `BFFS_IDX_FC_PU;
            end else if (addr == `BFFS_OFF_TT_PU) begin
                reg_index = `BFFS_IDX_TT_PU;
            end else if (addr == `BFFS_OFF_TT_DO) begin
                reg_index = `BFFS_IDX_TT_DO;
            end else if (addr == `BFFS_OFF_TRIP_MASK) begin
                reg_index = `BFFS_IDX_TRIP_MASK;
            end else if (addr == `BFFS_OFF_RMS_THR) begin
                reg_index = `BFFS_IDX_RMS_THR;
            end else if (addr == `BFFS_OFF_STATUS) begin
                reg_index = `BFFS_IDX_STATUS;
            end else begin
                reg_index = `BFFS_IDX_NONE;
            end
        end
    endfunction

    reg  [2:0]  scheme_ff;
    reg  [12:0] ft_thr_ff;
    reg  [15:0] fc_pu_ff;
    reg  [15:0] tt_pu_ff;
    reg  [15:0] tt_do_ff;
    reg  [23:0] trip_mask_ff;
    reg  [12:0] rms_thr_ff;
    reg  [17:0] tick_cnt_ff;
    reg         tick_ff;
    reg  [7:0]  sync1_ff;
    reg  [7:0]  sync2_ff;
    reg  [7:0]  sync3_ff;
    reg  [7:0]  status_ff;

    wire [3:0]  idx_w     = reg_index(paddr_i);
    wire        access_w  = psel_i & penable_i;
    wire        wr_take_w = access_w & pready_o & pwrite_i;
    wire [47:0] mag_w     = {phase_c_mag_i, phase_b_mag_i, phase_a_mag_i};
    wire [16:0] tt_lim_w  = {1'b0, tt_pu_ff} + {1'b0, tt_do_ff};
    wire [2:0]  fbf_w;
    wire [2:0]  fd_w;
    wire [2:0]  open_w;

    assign breaker_failure_flag_o = fbf_w;
    assign phase_fault_detect_o   = fd_w;
    assign phase_open_detect_o    = open_w;

    // APB: one wait state, write and read data at the pready edge
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h00000000;
        end else begin
            pready_o  <= access_w & ~pready_o;
            // Unmapped offsets answer with an error and read zero
            pslverr_o <= access_w & ~pready_o & (idx_w == `BFFS_IDX_NONE);
            if (access_w & ~pready_o & ~pwrite_i) begin
                if (idx_w == `BFFS_IDX_CTRL) begin
                    prdata_o <= {29'h0, scheme_ff};
                end else if (idx_w == `BFFS_IDX_FT_THR) begin
                    prdata_o <= {19'h0, ft_thr_ff};
                end else if (idx_w == `BFFS_IDX_FC_PU) begin
                    prdata_o <= {16'h0, fc_pu_ff};
                end else if (idx_w == `BFFS_IDX_TT_PU) begin
                    prdata_o <= {16'h0, tt_pu_ff};
                end else if (idx_w == `BFFS_IDX_TT_DO) begin
                    prdata_o <= {16'h0, tt_do_ff};
                end else if (idx_w == `BFFS_IDX_TRIP_MASK) begin
                    prdata_o <= {8'h0, trip_mask_ff};
                end else if (idx_w == `BFFS_IDX_RMS_THR) begin
                    prdata_o <= {19'h0, rms_thr_ff};
                end else if (idx_w == `BFFS_IDX_STATUS) begin
                    prdata_o <= {16'h0, three_phase_rms_overcurrent_o, phase_rms_overcurrent_o,
                                 1'b0, open_w, 1'b0, fd_w, 1'b0, fbf_w};
                end else begin
                    prdata_o <= 32'h00000000;
                end
            end
        end
    end

    // Configuration registers
    // Status drops writes silently; unmapped offsets drop them and answer with a slave error
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scheme_ff    <= `BFFS_RST_CTRL;
            ft_thr_ff    <= `BFFS_RST_FT_THR;
            fc_pu_ff     <= `BFFS_RST_FC_PU;
            tt_pu_ff     <= `BFFS_RST_TT_PU;
            tt_do_ff     <= `BFFS_RST_TT_DO;
            trip_mask_ff <= `BFFS_RST_TRIP_MASK;
            rms_thr_ff   <= `BFFS_RST_RMS_THR;
        end else if (wr_take_w) begin
            if (idx_w == `BFFS_IDX_CTRL) begin
                scheme_ff <= pwdata_i[`BFFS_CTRL_SCH_MSB:0];
            end else if (idx_w == `BFFS_IDX_FT_THR) begin
                ft_thr_ff <= pwdata_i[`BFFS_THR_MSB:0];
            end else if (idx_w == `BFFS_IDX_FC_PU) begin
                fc_pu_ff <= pwdata_i[15:0];
            end else if (idx_w == `BFFS_IDX_TT_PU) begin
                tt_pu_ff <= pwdata_i[15:0];
            end else if (idx_w == `BFFS_IDX_TT_DO) begin
                tt_do_ff <= pwdata_i[15:0];
            end else if (idx_w == `BFFS_IDX_TRIP_MASK) begin
                trip_mask_ff <= pwdata_i[23:0];
            end else if (idx_w == `BFFS_IDX_RMS_THR) begin
                rms_thr_ff <= pwdata_i[`BFFS_THR_MSB:0];
            end
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_cnt_ff <= 18'h00000;
            tick_ff     <= 1'b0;
        end else if (tick_cnt_ff == TICK_LAST) begin
            tick_cnt_ff <= 18'h00000;
            tick_ff     <= 1'b1;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 18'h00001;
            tick_ff     <= 1'b0;
        end
    end

    // Status pins: accept a change once the last two stages agree
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_ff  <= 8'h00;
            sync2_ff  <= 8'h00;
            sync3_ff  <= 8'h00;
            status_ff <= 8'h00;
        end else begin
            sync1_ff <= status_bits_i;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            if (sync2_ff == sync3_ff) begin
                status_ff <= sync3_ff;
            end
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_rms_overcurrent_o       <= 3'h0;
            three_phase_rms_overcurrent_o <= 1'b0;
        end else begin
            phase_rms_overcurrent_o[0]    <= phase_a_rms_i > {3'h0, rms_thr_ff};
            phase_rms_overcurrent_o[1]    <= phase_b_rms_i > {3'h0, rms_thr_ff};
            phase_rms_overcurrent_o[2]    <= phase_c_rms_i > {3'h0, rms_thr_ff};
            three_phase_rms_overcurrent_o <= (phase_a_rms_i > {3'h0, rms_thr_ff}) &
                                             (phase_b_rms_i > {3'h0, rms_thr_ff}) &
                                             (phase_c_rms_i > {3'h0, rms_thr_ff});
        end
    end

    genvar ph;
    generate
        for (ph = 0; ph < 3; ph = ph + 1) begin : g_phase
            reg         cross_seen_ff;
            reg  [2:0]  quiet_ff;
            reg         open_ff;
            reg         fd_ff;
            reg         fd_prev_ff;
            reg  [1:0]  qual_ff;
            reg         latch_ff;
            reg  [16:0] cnt_ff;
            reg         fbf_ff;
            reg  [1:0]  nxt_qual;
            reg         nxt_latch;
            reg  [16:0] nxt_cnt;
            reg         nxt_fbf;
            reg         qin;
            reg         qualified;

            // Trip initiate from masked status bits
            wire        trip_w = |(status_ff & trip_mask_ff[ph*8+7:ph*8]);
            wire        xing_w = current_zero_cross_i[ph] | deriv_zero_cross_i[ph];
            wire [16:0] cnt_inc_w = (cnt_ff == 17'h1FFFF) ? cnt_ff : cnt_ff + 17'h00001;

            assign fbf_w[ph]  = fbf_ff;
            assign fd_w[ph]   = fd_ff;
            assign open_w[ph] = open_ff;

            always @* begin
                nxt_qual  = 2'h0;
                nxt_latch = 1'b0;
                nxt_cnt   = 17'h00000;
                nxt_fbf   = 1'b0;
                // Scheme four qualifies on trip alone
                qin       = (scheme_ff == `BFFS_SCH_FOUR) ? trip_w : (trip_w & fd_ff);
                qualified = qin & (qual_ff >= (`BFFS_QTR_TICKS - 2'h1));
                if (qin) begin
                    nxt_qual = (qual_ff == `BFFS_QTR_TICKS) ? qual_ff : qual_ff + 2'h1;
                end
                case (scheme_ff)
                    `BFFS_SCH_TWO: begin
                        if (!fd_ff) begin
                            nxt_latch = 1'b0;
                        end else if (latch_ff) begin
                            nxt_latch = 1'b1;
                            nxt_cnt   = cnt_inc_w;
                        end else if (qualified) begin
                            nxt_latch = 1'b1;
                        end
                        // Flag at expiry with detector held
                        nxt_fbf = nxt_latch & (nxt_cnt >= {1'b0, fc_pu_ff});
                    end
                    `BFFS_SCH_THREE: begin
                        if (trip_w & fd_ff) begin
                            nxt_latch = 1'b1;
                            nxt_cnt   = latch_ff ? cnt_inc_w : 17'h00000;
                        end
                        nxt_fbf = nxt_latch & (nxt_cnt >= {1'b0, fc_pu_ff});
                    end
                    `BFFS_SCH_FOUR: begin
                        if (latch_ff) begin
                            // Stop one tick early so the hold window is TT_DO ticks
                            if (cnt_inc_w < tt_lim_w) begin
                                nxt_latch = 1'b1;
                                nxt_cnt   = cnt_inc_w;
                            end
                        end else if (qualified) begin
                            // Zero-length window would otherwise latch for one tick
                            nxt_latch = (tt_lim_w != 17'h00000);
                        end
                        nxt_fbf = fd_ff & nxt_latch & (nxt_cnt >= {1'b0, tt_pu_ff});
                    end
                    `BFFS_SCH_FIVE: begin
                        // Start on trip, reset on trip or detector drop
                        // Only a falling detector edge resets; a low level keeps timing
                        if (trip_w & ~(fd_prev_ff & ~fd_ff)) begin
                            nxt_latch = 1'b1;
                            nxt_cnt   = latch_ff ? cnt_inc_w : 17'h00000;
                        end
                        nxt_fbf = fd_ff & nxt_latch & (nxt_cnt >= {1'b0, fc_pu_ff});
                    end
                    default: begin
                        // Off, one and custom produce no output here
                        nxt_qual = 2'h0;
                    end
                endcase
            end

            always @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    cross_seen_ff <= 1'b0;
                    quiet_ff      <= 3'h0;
                    open_ff       <= 1'b0;
                    fd_ff         <= 1'b0;
                    fd_prev_ff    <= 1'b0;
                end else if (tick_ff) begin
                    // Crossing in the tick cycle itself is kept for the next interval
                    cross_seen_ff <= xing_w;
                    if (cross_seen_ff | xing_w) begin
                        quiet_ff <= 3'h0;
                        open_ff  <= 1'b0;
                    end else if (quiet_ff == `BFFS_OPEN_TICKS - 3'h1) begin
                        quiet_ff <= `BFFS_OPEN_TICKS;
                        open_ff  <= 1'b1;
                    // Count saturates so the open flag holds
                    end else if (quiet_ff != `BFFS_OPEN_TICKS) begin
                        quiet_ff <= quiet_ff + 3'h1;
                    end
                    fd_prev_ff <= fd_ff;
                    fd_ff      <= ~open_ff & (mag_w[ph*16+15:ph*16] > {3'h0, ft_thr_ff});
                end else if (xing_w) begin
                    cross_seen_ff <= 1'b1;
                end
            end

            always @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    qual_ff  <= 2'h0;
                    latch_ff <= 1'b0;
                    cnt_ff   <= 17'h00000;
                    fbf_ff   <= 1'b0;
                end else if (tick_ff) begin
                    qual_ff  <= nxt_qual;
                    latch_ff <= nxt_latch;
                    cnt_ff   <= nxt_cnt;
                    fbf_ff   <= nxt_fbf;
                end
            end
        end
    endgenerate

endmodule // bffs_core

/* bench/bffs_relay_model.sv */
// Protective relay model driving the trip initiates after a chosen delay
`timescale 1ns/10ps
module bffs_relay_model (
    input  wire        clk_i,
    input  wire        rst_n_i,
    input  wire [2:0]  trip_req_i,
    input  wire [3:0]  delay_i,
    output reg  [7:0]  status_bits_o
);
    reg [3:0] wait_ff;
    // Slow or prompt contact closure; release drops the initiate at once
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_ff       <= 4'h0;
            status_bits_o <= 8'h00;
        end else if (trip_req_i == 3'h0) begin
            wait_ff       <= 4'h0;
            status_bits_o <= 8'h00;
        end else if (wait_ff < delay_i) begin
            wait_ff <= wait_ff + 4'h1;
        end else begin
            status_bits_o <= {5'h00, trip_req_i};
        end
    end
endmodule // bffs_relay_model

/* bench/bffs_core_props.sv */
// Port-level assertions for the breaker-failure block
`timescale 1ns/10ps
module bffs_core_props #(
    parameter TICK_CYCLES = 8
) (
    input wire        clk_i,
    input wire        rst_n_i,
    input wire        pready_o,
    input wire        pslverr_o,
    input wire [2:0]  breaker_failure_flag_o,
    input wire [2:0]  phase_fault_detect_o,
    input wire [2:0]  phase_open_detect_o,
    input wire [2:0]  phase_rms_overcurrent_o,
    input wire        three_phase_rms_overcurrent_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Repetition counts assume the short simulation tick of eight clocks
    AST_FLAG_TICK: assert property ($changed(breaker_failure_flag_o) |=> $stable(breaker_failure_flag_o)[*7])
        else $error("failure flag changed between ticks");
    AST_FD_TICK: assert property ($changed(phase_fault_detect_o) |=> $stable(phase_fault_detect_o)[*7])
        else $error("fault detect changed between ticks");
    AST_OPEN_TICK: assert property ($changed(phase_open_detect_o) |=> $stable(phase_open_detect_o)[*7])
        else $error("open detect changed between ticks");
    AST_FLAG_NEEDS_FD: assert property ((breaker_failure_flag_o & ~$past(phase_fault_detect_o, 8)
        & ~$past(phase_fault_detect_o, 16)) == 3'h0)
        else $error("failure flag without fault detect");
    AST_FLAG_CLEARS: assert property ($fell(phase_fault_detect_o[0])
        |-> ##[1:24] (!breaker_failure_flag_o[0] || phase_fault_detect_o[0]))
        else $error("failure flag kept after detector dropout");
    AST_OPEN_KILLS_FD: assert property ((phase_fault_detect_o & $past(phase_open_detect_o, 8)) == 3'h0)
        else $error("fault detect high on open phase");
    AST_RMS_THREE: assert property (three_phase_rms_overcurrent_o == &phase_rms_overcurrent_o)
        else $error("three-phase rms flag mismatch");
    AST_READY_PULSE: assert property (pready_o |=> !pready_o)
        else $error("ready held two cycles");
    AST_ERR_WITH_READY: assert property (pslverr_o |-> pready_o)
        else $error("slave error without ready");
endmodule // bffs_core_props

bind bffs_core bffs_core_props #(.TICK_CYCLES(TICK_CYCLES)) i_bffs_core_props (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .breaker_failure_flag_o(breaker_failure_flag_o), .phase_fault_detect_o(phase_fault_detect_o),
    .phase_open_detect_o(phase_open_detect_o), .phase_rms_overcurrent_o(phase_rms_overcurrent_o),
    .three_phase_rms_overcurrent_o(three_phase_rms_overcurrent_o));

/* bench/bffs_core_bench.sv */
// Self-checking bench for the breaker-failure block
`timescale 1ns/10ps
`include "bffs_regs.vh"
module bffs_core_bench;
    localparam int TK = 8;
    localparam int FCP = 8;
    localparam int TTP = 4;
    localparam int TTD = 3;
    typedef struct packed {logic [2:0] sch; logic [7:0] trip; logic [7:0] mag; logic [2:0] ph; logic exp;} bffs_row_t;
    logic        clk_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o;
    logic        pready_o, pslverr_o, rms3_o, xing_en = 1'b1;
    logic [7:0]  status_bits;
    logic [15:0] mag = 16'h0, rms_a = 16'h0, rms_b = 16'h0, rms_c = 16'h0;
    logic [2:0]  cur_zc = 3'h0, der_zc = 3'h0, trip_req = 3'h0, flag_o, fd_o, open_o, rms_o;
    logic [3:0]  delay = 4'h1;
    logic [1:0]  xc = 2'h0;
    int          bad_count = 0, checked = 0;
    bffs_row_t   rows [14] = '{
        '{3'h2, 8'h28, 8'h28, 3'h7, 1'b1}, '{3'h2, 8'h05, 8'h28, 3'h7, 1'b1}, '{3'h2, 8'h28, 8'h04, 3'h7, 1'b0},
        '{3'h3, 8'h28, 8'h28, 3'h2, 1'b1}, '{3'h3, 8'h05, 8'h28, 3'h7, 1'b0}, '{3'h3, 8'h28, 8'h04, 3'h7, 1'b0},
        '{3'h4, 8'h05, 8'h28, 3'h7, 1'b1}, '{3'h4, 8'h05, 8'h02, 3'h7, 1'b0}, '{3'h5, 8'h28, 8'h28, 3'h4, 1'b1},
        '{3'h5, 8'h05, 8'h28, 3'h7, 1'b0}, '{3'h5, 8'h28, 8'h03, 3'h7, 1'b0}, '{3'h0, 8'h28, 8'h28, 3'h7, 1'b0},
        '{3'h1, 8'h28, 8'h28, 3'h7, 1'b0}, '{3'h6, 8'h28, 8'h28, 3'h7, 1'b0}};

    bffs_core #(.TICK_CYCLES(TK)) i_bffs_core (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .status_bits_i(status_bits), .phase_a_mag_i(mag), .phase_b_mag_i(mag), .phase_c_mag_i(mag),
        .phase_a_rms_i(rms_a), .phase_b_rms_i(rms_b), .phase_c_rms_i(rms_c), .current_zero_cross_i(cur_zc),
        .deriv_zero_cross_i(der_zc), .breaker_failure_flag_o(flag_o), .phase_fault_detect_o(fd_o),
        .phase_open_detect_o(open_o), .phase_rms_overcurrent_o(rms_o), .three_phase_rms_overcurrent_o(rms3_o));
    bffs_relay_model i_bffs_relay_model (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .trip_req_i(trip_req), .delay_i(delay), .status_bits_o(status_bits));

    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // Crossings keep the phases closed unless a test stops them
    always @(posedge clk_i) begin
        xc <= xc + 2'h1;
        cur_zc <= (xing_en && xc == 2'h0) ? 3'h7 : 3'h0;
        der_zc <= (xing_en && xc == 2'h2) ? 3'h7 : 3'h0;
    end

    task automatic complete_run;
        if (bad_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n;
        n = 0;
        // Idle edge first, so back-to-back calls never reassign psel in one step
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        q = prdata_o;
        e = pslverr_o;
        if (n >= 50) chk(32'h0, 32'h1, "bus answer missing");
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic expe);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, exp, "read data");
        chk({31'h0, e}, {31'h0, expe}, "slave error");
    endtask

    initial begin
        int i, t, hi, first, lo;
        logic [2:0] seen;
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        wr(`BFFS_OFF_FC_PU, FCP);
        wr(`BFFS_OFF_TT_PU, TTP);
        wr(`BFFS_OFF_TT_DO, TTD);
        for (i = 0; i < 14; i++) begin
            wr(`BFFS_OFF_CTRL, {29'h0, rows[i].sch});
            delay <= i[0] ? 4'h6 : 4'h1;
            seen = 3'h0;
            hi = 0;
            first = -1;
            for (t = 0; t < 40*TK; t++) begin
                trip_req <= (t < rows[i].trip*TK) ? rows[i].ph : 3'h0;
                mag <= (t < rows[i].mag*TK) ? 16'h00C8 : 16'h0000;
                @(posedge clk_i);
                seen = seen | flag_o;
                if (flag_o !== 3'h0) begin
                    hi++;
                    if (first < 0) first = t;
                end
            end
            chk(seen, rows[i].exp ? rows[i].ph : 3'h0, "failure flag");
            if (rows[i].exp) begin
                lo = (rows[i].sch == 3'h4) ? TTP : FCP;
                chk(first >= lo*TK && first <= (lo+7)*TK, 1'b1, "flag delay");
                if (rows[i].sch == 3'h4) chk(hi == TTD*TK, 1'b1, "hold width");
            end
            trip_req <= 3'h0;
            mag <= 16'h0;
            repeat (16*TK) @(posedge clk_i);
        end
        // One initiate shared by all phases through the mask
        wr(`BFFS_OFF_TRIP_MASK, 32'h010101);
        wr(`BFFS_OFF_CTRL, 32'h3);
        trip_req <= 3'h1;
        mag <= 16'h00C8;
        repeat (20*TK) @(posedge clk_i);
        chk(flag_o, 3'h7, "shared initiate");
        trip_req <= 3'h0;
        mag <= 16'h0032;
        repeat (3*TK) @(posedge clk_i);
        chk(fd_o, 3'h0, "detect at threshold");
        mag <= 16'h0033;
        repeat (3*TK) @(posedge clk_i);
        chk(fd_o, 3'h7, "detect above threshold");
        rd(`BFFS_OFF_STATUS, 32'h70, 1'b0);
        xing_en <= 1'b0;
        repeat (9*TK) @(posedge clk_i);
        chk(open_o, 3'h7, "phase open");
        chk(fd_o, 3'h0, "detect forced low");
        xing_en <= 1'b1;
        repeat (3*TK) @(posedge clk_i);
        chk(open_o, 3'h0, "phase closed");
        mag <= 16'h0;
        rms_a <= 16'h0033;
        repeat (3) @(posedge clk_i);
        chk({rms_o, rms3_o}, 4'h2, "rms one phase");
        rms_b <= 16'h0033;
        rms_c <= 16'h0033;
        repeat (3) @(posedge clk_i);
        chk({rms_o, rms3_o}, 4'hF, "rms all phases");
        rms_a <= 16'h0032;
        repeat (3) @(posedge clk_i);
        chk({rms_o, rms3_o}, 4'hC, "rms at threshold");
        // Mid-run reset: outputs and registers return to reset values
        rms_b <= 16'h0;
        rms_c <= 16'h0;
        rst_n_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        chk({17'h0, flag_o, fd_o, open_o, rms_o, rms3_o, pready_o, pslverr_o}, 32'h0, "outputs after reset");
        chk(prdata_o, 32'h0, "read data after reset");
        rd(`BFFS_OFF_CTRL, 32'h0, 1'b0);
        rd(`BFFS_OFF_FT_THR, 32'h32, 1'b0);
        rd(`BFFS_OFF_FC_PU, 32'h20, 1'b0);
        rd(`BFFS_OFF_TT_PU, 32'h20, 1'b0);
        rd(`BFFS_OFF_TT_DO, 32'h8, 1'b0);
        rd(`BFFS_OFF_TRIP_MASK, 32'h040201, 1'b0);
        rd(`BFFS_OFF_RMS_THR, 32'h32, 1'b0);
        rd(8'h20, 32'h0, 1'b1);
        wr(`BFFS_OFF_STATUS, 32'hFFFFFFFF);
        rd(`BFFS_OFF_STATUS, 32'h0, 1'b0);
        wr(`BFFS_OFF_CTRL, 32'hFFFFFFFF);
        rd(`BFFS_OFF_CTRL, 32'h7, 1'b0);
        complete_run;
    end
    initial begin
        #500000;
        bad_count++;
        complete_run;
    end
endmodule // bffs_core_bench
